// ---- shared/smc_pkg.sv ----
// constants, types and address decode for the switch matrix control block
`default_nettype none
package smc_pkg;

  // ********************************************
  // register byte addresses
  // ********************************************
  localparam logic [15:0] ADDR_CFG = 16'h200c;  // switch_config
  localparam logic [15:0] ADDR_DF  = 16'h2150;  // drive_switch_full
  localparam logic [15:0] ADDR_NF  = 16'h2154;  // negative_switch_full
  localparam logic [15:0] ADDR_PF  = 16'h2158;  // positive_switch_full
  localparam logic [15:0] ADDR_TF  = 16'h215c;  // tia_switch_full
  localparam logic [15:0] ADDR_DS  = 16'h21b0;  // drive_switch_state
  localparam logic [15:0] ADDR_PS  = 16'h21b4;  // positive_switch_state
  localparam logic [15:0] ADDR_NS  = 16'h21b8;  // negative_switch_state
  localparam logic [15:0] ADDR_TS  = 16'h21bc;  // tia_switch_state

  // ********************************************
  // switch_config fields and reset values
  // ********************************************
  localparam logic [31:0] CFG_RESET = 32'h0000ffff;  // all selectors 1111
  localparam logic [31:0] CFG_MASK  = 32'h0007ffff;  // bits 31..19 reserved
  localparam int          SRC_BIT   = 16;  // per_switch_source_select
  localparam int          T9_BIT    = 17;  // tia_ninth_switch_ctrl
  localparam int          T10_BIT   = 18;  // tia_tenth_switch_ctrl
  localparam int          TSEL_LSB  = 12;  // tia_group_selector
  localparam int          NSEL_LSB  = 8;   // negative_group_selector
  localparam int          PSEL_LSB  = 4;   // positive_group_selector
  localparam int          DSEL_LSB  = 0;   // drive_group_selector

  // ********************************************
  // switch positions inside each group vector
  // ********************************************
  localparam int          T_NINTH   = 8;   // ninth tia input switch
  localparam int          T_TENTH   = 9;   // tenth tia input switch
  localparam int          T_CAL     = 11;  // tia_calibration_switch
  localparam int          N_NINTH   = 8;   // N9
  localparam int          N_CAL     = 9;   // negative_calibration_switch
  localparam int          N_SHORT   = 10;  // negative_short_switch
  localparam int          N_LDO2    = 11;  // negative_ldo_second_switch
  localparam int          P_LDO     = 13;  // positive_ldo_switch
  localparam int          P_LDO2    = 14;  // positive_ldo_second_switch
  localparam logic [15:0] T_ALL     = 16'h087f;  // T1..T7 and calibration
  localparam logic [15:0] D_ALL     = 16'h00ff;  // calibration and D2..D8
  localparam logic [15:0] SW_OPEN   = 16'h0000;  // every switch open

  // writable bits of the full-configuration registers: t, p, n, d
  localparam logic [3:0][31:0] FULL_MASK = {32'h00000fff, 32'h00007fff,
                                            32'h00000fff, 32'h000000ff};

  // ********************************************
  // types
  // ********************************************
  typedef struct packed {
    logic [15:0] t;  // tia input group
    logic [15:0] n;  // negative node group
    logic [15:0] p;  // positive node group
    logic [15:0] d;  // drive output group
  } smc_switch_t;

  typedef enum logic [3:0] {
    R_DF = 4'h0, R_NF = 4'h1, R_PF = 4'h2, R_TF = 4'h3,
    R_CFG = 4'h4, R_DS = 4'h5, R_PS = 4'h6, R_NS = 4'h7,
    R_TS = 4'h8, R_NONE = 4'h9
  } smc_reg_t;

  typedef struct packed {
    logic [31:0]      cfg;     // switch_config
    logic [3:0][31:0] full;    // written full-configuration values
    logic [3:0][31:0] act;     // values latched by source select
    smc_switch_t      sw;      // driven switch enables
    logic             pready;  // apb ready
    logic [31:0]      prdata;  // apb read data
    logic             pslverr; // apb error
  } smc_state_t;

  // address to register, used by read and write paths
  function automatic smc_reg_t smc_decode(input logic [15:0] a);
    unique case (a)
      ADDR_CFG: smc_decode = R_CFG;
      ADDR_DF:  smc_decode = R_DF;
      ADDR_NF:  smc_decode = R_NF;
      ADDR_PF:  smc_decode = R_PF;
      ADDR_TF:  smc_decode = R_TF;
      ADDR_DS:  smc_decode = R_DS;
      ADDR_PS:  smc_decode = R_PS;
      ADDR_NS:  smc_decode = R_NS;
      ADDR_TS:  smc_decode = R_TS;
      default:  smc_decode = R_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- logic/smc_group_decode.sv ----
// group selector decode of switch_config into switch enables, at most one closed per group bar tia and drive code 9 and the tia ninth, tenth
`timescale 1ns/1ps
`default_nettype none

module smc_group_decode (
  input  wire logic [31:0]        cfg,
  output smc_pkg::smc_switch_t    dec
);

  // code k closes the switch at position k-1
  function automatic logic [15:0] smc_onehot(input logic [3:0] code);
    logic [3:0] idx;
    idx = code - 4'h1;
    smc_onehot = 16'h0001 << idx;
  endfunction

  logic [3:0] tsel;  // tia_group_selector
  logic [3:0] nsel;  // negative_group_selector
  logic [3:0] psel;  // positive_group_selector
  logic [3:0] dsel;  // drive_group_selector

  assign tsel = cfg[smc_pkg::TSEL_LSB +: 4];
  assign nsel = cfg[smc_pkg::NSEL_LSB +: 4];
  assign psel = cfg[smc_pkg::PSEL_LSB +: 4];
  assign dsel = cfg[smc_pkg::DSEL_LSB +: 4];

  // ********************************************
  // per-group decode
  // ********************************************
  // reserved codes open the whole group, bar the tia ninth and tenth, so a bad write never shorts nodes
  always_comb
  begin
    dec = '0;
    case (tsel) inside
      [4'h1:4'h7]: dec.t = smc_onehot(tsel);
      4'h8:        dec.t[smc_pkg::T_CAL] = 1'b1;
      4'h9:        dec.t = smc_pkg::T_ALL;
      default:     dec.t = smc_pkg::SW_OPEN;
    endcase
    // ninth and tenth follow only their own bits
    dec.t[smc_pkg::T_NINTH] = cfg[smc_pkg::T9_BIT];
    dec.t[smc_pkg::T_TENTH] = cfg[smc_pkg::T10_BIT];
    case (nsel) inside
      4'h0:        dec.n[smc_pkg::N_SHORT] = 1'b1;
      [4'h1:4'h7]: dec.n = smc_onehot(nsel);
      4'h9:        dec.n[smc_pkg::N_NINTH] = 1'b1;
      4'ha:        dec.n[smc_pkg::N_CAL] = 1'b1;
      [4'hb:4'he]: dec.n[smc_pkg::N_LDO2] = 1'b1;
      default:     dec.n = smc_pkg::SW_OPEN;
    endcase
    case (psel) inside
      4'h0:        dec.p[smc_pkg::P_LDO] = 1'b1;
      [4'h1:4'h9]: dec.p = smc_onehot(psel);
      4'hb:        dec.p = smc_onehot(psel);
      [4'hd:4'he]: dec.p[smc_pkg::P_LDO2] = 1'b1;
      default:     dec.p = smc_pkg::SW_OPEN;
    endcase
    case (dsel) inside
      [4'h1:4'h8]: dec.d = smc_onehot(dsel);
      4'h9:        dec.d = smc_pkg::D_ALL;
      default:     dec.d = smc_pkg::SW_OPEN;
    endcase
  end

endmodule
`default_nettype wire

// ---- logic/smc_switch_ctrl.sv ----
// apb register bank and switch enable drive for the switch matrix
//
// Notes on behaviour
// - source bit picks full registers or groups
// - bit 18 closes tenth tia switch
// - bit 17 closes ninth tia switch
// - tia selector decodes per table
// - tia selector leaves ninth, tenth alone
// - negative selector decodes per table
// - positive selector decodes per table
// - drive selector decodes per table
// - config resets to 0x0000ffff
// - four full registers read/write, reset zero
// - status registers read-only, reset zero
// - full changes apply on later source set
// - all switches open after reset
// - status shows actually driven switch state
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module smc_switch_ctrl (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [15:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output smc_pkg::smc_switch_t    sw_en
);

  // ********************************************
  // state and helpers
  // ********************************************
  smc_pkg::smc_state_t  st_reg;   // all state of the block
  smc_pkg::smc_state_t  st_next;  // next value of the state
  smc_pkg::smc_switch_t dec;      // group decode result
  smc_pkg::smc_reg_t    rsel;     // decoded register
  logic                 setup;    // apb setup phase
  logic                 commit;   // access phase completes
  logic [1:0]           fidx;     // full register index

  assign rsel   = smc_pkg::smc_decode(paddr);
  assign setup  = psel & ~penable;
  assign commit = psel & penable & st_reg.pready;
  assign fidx   = rsel[1:0];

  // group decode works from the live configuration register
  smc_group_decode u_dec (
    .cfg (st_reg.cfg),
    .dec (dec)
  );

  // ********************************************
  // next state
  // ********************************************
  // answer is prepared in setup so every bus output is a flop;
  // the cost is one fixed cycle, never a wait state
  always_comb
  begin
    st_next = st_reg;
    st_next.pready = 1'b0;
    // setup: register read data and error for the access phase
    if (setup)
    begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (rsel == smc_pkg::R_NONE);
      unique case (rsel)
        smc_pkg::R_CFG:
          st_next.prdata = st_reg.cfg;
        smc_pkg::R_DF, smc_pkg::R_NF, smc_pkg::R_PF, smc_pkg::R_TF:
          st_next.prdata = st_reg.full[fidx];
        smc_pkg::R_DS:
          st_next.prdata = {16'h0000, st_reg.sw.d};
        smc_pkg::R_PS:
          st_next.prdata = {16'h0000, st_reg.sw.p};
        smc_pkg::R_NS:
          st_next.prdata = {16'h0000, st_reg.sw.n};
        smc_pkg::R_TS:
          st_next.prdata = {16'h0000, st_reg.sw.t};
        default:
          st_next.prdata = 32'h00000000;
      endcase
    end
    // writes land only at the completing edge
    if (commit && pwrite)
    begin
      unique case (rsel)
        smc_pkg::R_CFG:
        begin
          st_next.cfg = pwdata & smc_pkg::CFG_MASK;
          if (pwdata[smc_pkg::SRC_BIT])
          begin
            st_next.act = st_reg.full;
          end
        end
        smc_pkg::R_DF, smc_pkg::R_NF, smc_pkg::R_PF, smc_pkg::R_TF:
          st_next.full[fidx] = pwdata & smc_pkg::FULL_MASK[fidx];
        default:
          st_next.full = st_reg.full;
      endcase
    end
    if (st_reg.cfg[smc_pkg::SRC_BIT])
    begin
      st_next.sw.d = st_reg.act[0][15:0];
      st_next.sw.n = st_reg.act[1][15:0];
      st_next.sw.p = st_reg.act[2][15:0];
      st_next.sw.t = st_reg.act[3][15:0];
    end
    else
    begin
      st_next.sw = dec;
    end
  end

  // ********************************************
  // state register
  // ********************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg.cfg     <= smc_pkg::CFG_RESET;
      st_reg.full    <= '0;
      st_reg.act     <= '0;
      st_reg.sw      <= '0;
      st_reg.pready  <= 1'b0;
      st_reg.prdata  <= 32'h00000000;
      st_reg.pslverr <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign sw_en   = st_reg.sw;

  // ********************************************
  // assertions
  // ********************************************
  logic grp;  // group control in effect
  assign grp = ~st_reg.cfg[smc_pkg::SRC_BIT];

  property p_src_full;
    @(posedge clk_sys) disable iff (srst)
    !grp |=> sw_en.d == $past(st_reg.act[0][15:0])
         && sw_en.t == $past(st_reg.act[3][15:0]);
  endproperty
  a_src_full: assert property (p_src_full)
    else $error("full source not driving switches");

  property p_tenth;
    @(posedge clk_sys) disable iff (srst)
    grp |=> sw_en.t[smc_pkg::T_TENTH] == $past(st_reg.cfg[smc_pkg::T10_BIT]);
  endproperty
  a_tenth: assert property (p_tenth)
    else $error("tenth tia switch wrong");

  property p_ninth;
    @(posedge clk_sys) disable iff (srst)
    grp |=> sw_en.t[smc_pkg::T_NINTH] == $past(st_reg.cfg[smc_pkg::T9_BIT]);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth tia switch wrong");

  property p_tcal;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[15:12] == 4'h8
      |=> (sw_en.t & 16'hfcff) == 16'h0800;
  endproperty
  a_tcal: assert property (p_tcal)
    else $error("tia code 1000 wrong");

  property p_tall_keeps;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[15:12] == 4'h9
      |=> (sw_en.t & 16'hfcff) == smc_pkg::T_ALL
       && sw_en.t[9:8] == $past(st_reg.cfg[18:17]);
  endproperty
  a_tall_keeps: assert property (p_tall_keeps)
    else $error("tia all-closed touched ninth or tenth");

  property p_nres;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[11:8] == 4'h8 |=> sw_en.n == 16'h0000;
  endproperty
  a_nres: assert property (p_nres)
    else $error("negative reserved code closed a switch");

  property p_p11;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[7:4] == 4'hb |=> sw_en.p == 16'h0400;
  endproperty
  a_p11: assert property (p_p11)
    else $error("positive code 1011 wrong");

  property p_dall;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[3:0] == 4'h9 |=> sw_en.d == 16'h00ff;
  endproperty
  a_dall: assert property (p_dall)
    else $error("drive all-closed wrong");

  property p_open_reset;
    @(posedge clk_sys)
    $fell(srst) |-> sw_en == '0 && st_reg.cfg == 32'h0000ffff
                    ##1 sw_en == '0;
  endproperty
  a_open_reset: assert property (p_open_reset)
    else $error("switches not open after reset");

  property p_full_hold;
    @(posedge clk_sys) disable iff (srst)
    commit && pwrite && rsel inside {smc_pkg::R_DF, smc_pkg::R_TF}
      |=> $stable(st_reg.act);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full write took effect without source set");

  property p_status;
    @(posedge clk_sys) disable iff (srst)
    setup && rsel == smc_pkg::R_NS |=> pready
      && prdata == {16'h0000, $past(sw_en.n)};
  endproperty
  a_status: assert property (p_status)
    else $error("status read mismatch");

  property p_cfg_rsvd;
    @(posedge clk_sys) disable iff (srst)
    setup && rsel == smc_pkg::R_CFG |=> prdata[31:19] == 13'h0000;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("reserved config bits read nonzero");

  property p_cfg_reset;
    @(posedge clk_sys)
    $fell(srst) |-> grp && st_reg.cfg == smc_pkg::CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config not at reset value");

  property p_full_read;
    @(posedge clk_sys) disable iff (srst)
    setup && rsel inside {smc_pkg::R_DF, smc_pkg::R_NF, smc_pkg::R_PF, smc_pkg::R_TF}
      |=> prdata == $past(st_reg.full[fidx]) && !pslverr;
  endproperty
  a_full_read: assert property (p_full_read)
    else $error("full register read mismatch");

  property p_status_ro;
    @(posedge clk_sys) disable iff (srst)
    commit && pwrite
      && rsel inside {smc_pkg::R_DS, smc_pkg::R_PS, smc_pkg::R_NS, smc_pkg::R_TS}
      |=> $stable(st_reg.cfg) && $stable(st_reg.full) && !pslverr;
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write changed a register");

  property p_full_latch;
    @(posedge clk_sys) disable iff (srst)
    commit && pwrite && rsel == smc_pkg::R_CFG && pwdata[smc_pkg::SRC_BIT]
      |=> st_reg.act == $past(st_reg.full);
  endproperty
  a_full_latch: assert property (p_full_latch)
    else $error("source set did not latch full values");

  property p_nldo2;
    @(posedge clk_sys) disable iff (srst)
    grp && st_reg.cfg[11:8] >= 4'hb && st_reg.cfg[11:8] <= 4'he
      |=> sw_en.n == 16'h0800;
  endproperty
  a_nldo2: assert property (p_nldo2)
    else $error("negative ldo second code wrong");

  property p_pres;
    @(posedge clk_sys) disable iff (srst)
    grp && (st_reg.cfg[7:4] == 4'ha || st_reg.cfg[7:4] == 4'hc)
      |=> sw_en.p == 16'h0000;
  endproperty
  a_pres: assert property (p_pres)
    else $error("positive reserved code closed a switch");

endmodule
`default_nettype wire

// ---- testbench/test_switch_matrix_control.sv ----
// self-checking bench for the switch matrix control register bank
`timescale 1ns/1ps
`default_nettype none

module test_switch_matrix_control;
  logic                 clk_sys      = 1'b0;          // system clock
  logic                 srst         = 1'b1;          // sync reset, high
  logic                 psel         = 1'b0;          // apb select
  logic                 penable      = 1'b0;          // apb enable
  logic                 pwrite       = 1'b0;          // apb direction
  logic [15:0]          paddr        = 16'h0000;      // apb address
  logic [31:0]          pwdata       = 32'h00000000;  // apb write data
  logic [31:0]          prdata;                       // apb read data
  logic                 pready;                       // apb ready
  logic                 pslverr;                      // apb error
  smc_pkg::smc_switch_t sw_en;                        // switch enables
  int                   err_count    = 0;             // mismatches
  int                   total_checks = 0;             // comparisons
  logic [31:0]          rd;                           // last read data
  logic                 er;                           // last error flag
  logic [31:0]          cfg_m;                        // model of switch_config
  logic [3:0][31:0]     fl;                           // model of full registers
  logic [3:0][31:0]     lt;                           // model of latched copies

  // ********************************************
  // clock and design
  // ********************************************
  always #5 clk_sys = ~clk_sys;

  smc_switch_ctrl dut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_en(sw_en)
  );

  // ********************************************
  // report and compare
  // ********************************************
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // bounded wait: a missing ready must not hang the run
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        results();
      end
      @(posedge clk_sys);
    end
    // ready seen at this edge: take the answer here, then release
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ********************************************
  // expected switch state, worked out independently
  // ********************************************
  // group decode, g: 0 drive, 1 positive, 2 negative, 3 tia
  function automatic logic [15:0] dec(input int g, input logic [3:0] c);
    dec = 16'h0000;
    case (g)
      0: if (c >= 4'h1 && c <= 4'h8) dec[c - 4'h1] = 1'b1;
         else if (c == 4'h9) dec = 16'h00ff;
      1: if (c == 4'h0) dec[13] = 1'b1;
         else if (c <= 4'h9) dec[c - 4'h1] = 1'b1;
         else if (c == 4'hb) dec[10] = 1'b1;
         else if (c == 4'hd || c == 4'he) dec[14] = 1'b1;
      2: if (c == 4'h0) dec[10] = 1'b1;
         else if (c <= 4'h7) dec[c - 4'h1] = 1'b1;
         else if (c == 4'h9) dec[8] = 1'b1;
         else if (c == 4'ha) dec[9] = 1'b1;
         else if (c >= 4'hb && c <= 4'he) dec[11] = 1'b1;
      default: if (c >= 4'h1 && c <= 4'h7) dec[c - 4'h1] = 1'b1;
         else if (c == 4'h8) dec[11] = 1'b1;
         else if (c == 4'h9) dec = 16'h087f;
    endcase
  endfunction

  function automatic smc_pkg::smc_switch_t exp_sw;
    exp_sw.t = dec(3, cfg_m[15:12]);
    exp_sw.t[8] = cfg_m[17];
    exp_sw.t[9] = cfg_m[18];
    exp_sw.n = dec(2, cfg_m[11:8]);
    exp_sw.p = dec(1, cfg_m[7:4]);
    exp_sw.d = dec(0, cfg_m[3:0]);
    // full mode: latched copies drive every switch
    if (cfg_m[16])
      exp_sw = {lt[3][15:0], lt[1][15:0], lt[2][15:0], lt[0][15:0]};
  endfunction

  // switch outputs one edge after commit, then all four status words
  task automatic chk_sw;
    logic [15:0] sa [4];
    logic [15:0] g [4];
    smc_pkg::smc_switch_t e;
    e = exp_sw();
    sa = '{smc_pkg::ADDR_DS, smc_pkg::ADDR_PS, smc_pkg::ADDR_NS, smc_pkg::ADDR_TS};
    g = '{e.d, e.p, e.n, e.t};
    @(posedge clk_sys);
    #1;
    chk(sw_en, e);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, sa[i], 32'h00000000);
      chk({rd, 31'h0, er}, {16'h0000, g[i], 32'h0});
    end
  endtask

  task automatic cfg_wr(input logic [31:0] c);
    apb(1'b1, smc_pkg::ADDR_CFG, c);
    cfg_m = c & 32'h0007ffff;
    // source set copies the stored full values
    if (c[16])
      lt = fl;
    chk_sw();
  endtask

  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    cfg_m = 32'h0000ffff;
    fl = '0;
    lt = '0;
    #1;
    chk(sw_en, 64'h0);
    apb(1'b0, smc_pkg::ADDR_CFG, 32'h00000000);
    chk(rd, 32'h0000ffff);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, smc_pkg::ADDR_DF + 16'(4 * i), 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b0, smc_pkg::ADDR_DS + 16'(4 * i), 32'h00000000);
      chk(rd, 32'h00000000);
    end
  endtask

  // unmapped and misaligned places answer with an error
  task automatic t_unmapped;
    apb(1'b1, 16'h2010, 32'hffffffff);
    chk(er, 1'b1);
    apb(1'b0, 16'h200d, 32'h00000000);
    chk({rd, er}, 33'h1);
  endtask

  // every selector code, with the ninth and tenth bits toggling
  task automatic t_groups;
    logic [3:0] c;
    for (int k = 0; k < 16; k++)
    begin
      c = 4'(k);
      cfg_wr({13'h0000, c[1], c[0], 1'b0, c, c, c, c});
    end
  endtask

  task automatic t_reserved;
    apb(1'b1, smc_pkg::ADDR_CFG, 32'hfff80fff);
    cfg_m = 32'h00000fff;
    apb(1'b0, smc_pkg::ADDR_CFG, 32'h00000000);
    chk(rd, 32'h00000fff);
  endtask

  // stored full values act only after a later source set
  task automatic t_full(input logic [31:0] d, input logic [31:0] c);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, smc_pkg::ADDR_DF + 16'(4 * i), d);
      fl[i] = d & smc_pkg::FULL_MASK[i];
      apb(1'b0, smc_pkg::ADDR_DF + 16'(4 * i), 32'h00000000);
      chk(rd, fl[i]);
    end
    chk_sw();
    cfg_wr(c);
  endtask

  // the tia status word ignores writes and raises no error
  task automatic t_status_ro;
    apb(1'b1, smc_pkg::ADDR_TS, 32'hffffffff);
    chk(er, 1'b0);
    chk_sw();
  endtask

  initial
  begin
    t_reset();
    t_unmapped();
    t_groups();
    t_reserved();
    t_full(32'hffffffff, 32'h0001ffff);
    t_full(32'h5a5a5a5a, 32'h00070000);
    t_status_ro();
    cfg_wr(32'h00000000);
    t_reset();
    results();
  end
endmodule

`default_nettype wire
